/* File: logic/qumd_consts.svh */
/*
 * Offsets, field positions, reset values of the memory window decoder.
 * Assumes inclusion by the decoder design file and the testbench only.
 */
`ifndef QUMD_CONSTS_SVH
`define QUMD_CONSTS_SVH
`define QUMD_WIN_BYTES 33'h0_0000_1000
`define QUMD_CHREG_LAST 10'h00f
`define QUMD_SH_FIRST 10'h080
`define QUMD_SH_LAST 10'h09a
`define QUMD_FIFO_FIRST 10'h100
`define QUMD_FIFO_LAST 10'h1ff
`define QUMD_RXST_FIRST 10'h200
`define QUMD_SH_N 28
`define QUMD_SH_8X 5'h08
`define QUMD_SH_4X 5'h09
`define QUMD_SH_RST 5'h0a
`define QUMD_SH_SLP 5'h0b
`define QUMD_SH_REV 5'h0c
`define QUMD_SH_ID 5'h0d
`define QUMD_SH_MPSEL_LO 5'h13
`define QUMD_SH_MPSEL_HI 5'h19
`define QUMD_MPSEL_RST 8'hff
`define QUMD_TXW_W 38
`define QUMD_FIFO_D 8
`endif

/* File: logic/qumd_pkg.sv */
/*
 * Types of the memory window decoder.
 * Assumes qumd_consts.svh holds the numeric constants.
 */
package qumd_pkg;
    // access target, one-hot
    typedef enum logic [4:0] {
        TGT_NONE = 5'h01,
        TGT_CHREG = 5'h02,
        TGT_SHARED = 5'h04,
        TGT_FIFO = 5'h08,
        TGT_RXST = 5'h10
    } qumd_tgt_e;
endpackage : qumd_pkg

/* File: logic/qumd_decoder.sv */
/*
 * Memory window decoder of a four channel UART bridge, plus its TX FIFO.
 * Assumes host accesses stay inside one dword and that UART cores answer
 * register and RX reads combinationally in the strobe cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "qumd_consts.svh"

////////////////////////////////////////////////////////////////////////
// fifo with flop storage, index addressed
module qumd_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    // pointers carry a wrap bit so full and empty differ
    always_comb begin
        in_ready = (wp_q - rp_q) != (AW+1)'(D);
        out_valid = wp_q != rp_q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        out_data = mem_q[rp_q[AW-1:0]];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule : qumd_fifo

////////////////////////////////////////////////////////////////////////
module qumd_decoder #(
    parameter logic [7:0] REV_VALUE = 8'h01, // arbitrary
    parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // host access
    input wire logic [31:0] BASE_ADDR,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [31:0] REQ_ADDR,
    input wire logic [1:0] REQ_SIZE,
    input wire logic [31:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic [31:0] RSP_RDATA,
    // channel register port
    output logic CHREG_RD,
    output logic CHREG_WR,
    output logic [1:0] CHREG_CHANNEL,
    output logic [3:0] CHREG_INDEX,
    output logic [3:0] CHREG_BE,
    output logic [31:0] CHREG_WDATA,
    input wire logic [31:0] CHREG_RDATA,
    // receive data unload
    output logic RX_POP,
    output logic RX_POP_STATUS,
    output logic [1:0] RX_POP_CHANNEL,
    output logic [2:0] RX_POP_BYTES,
    input wire logic [31:0] RX_RDATA,
    // transmit data stream
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [1:0] TX_CHANNEL,
    output logic [3:0] TX_BE,
    output logic [31:0] TX_DATA,
    // shared configuration
    input wire logic [31:0] INT_STATUS,
    output logic [3:0] EIGHT_TIMES_SAMPLING_SELECT,
    output logic [3:0] FOUR_TIMES_SAMPLING_SELECT,
    output logic [3:0] SLEEP_SELECT,
    output logic [3:0] SOFT_RESET,
    input wire logic [3:0] SOFT_RESET_DONE,
    output logic [8*`QUMD_SH_N-1:0] CFG_BYTES
);
    import qumd_pkg::*;

    logic [32:0] rel;
    logic [9:0] off;
    logic [3:0] be;
    qumd_tgt_e tgt;
    logic take, txw;
    logic fifo_in_ready;
    logic st_v_q, st_v_d, st_wr_q, st_wr_d;
    logic [1:0] st_ch_q, st_ch_d;
    logic [9:0] st_off_q, st_off_d;
    logic [3:0] st_be_q, st_be_d;
    logic [31:0] st_wd_q, st_wd_d;
    qumd_tgt_e st_tgt_q, st_tgt_d;
    logic rsp_v_q, rsp_v_d;
    logic [31:0] rsp_q, rsp_d;
    logic [7:0] sh_q [`QUMD_SH_N];
    logic [7:0] sh_d [`QUMD_SH_N];
    logic [3:0] rst_q, rst_d;
    logic [3:0] rst_set;

    ////////////////////////////////////////////////////////////////////
    // decode of the incoming request
    always_comb begin
        rel = {1'b0, REQ_ADDR} - {1'b0, BASE_ADDR};
        off = rel[9:0];
        for (int k = 0; k < 4; k++) begin
            // lanes from start address; spill past the dword is dropped
            be[k] = (2'(k) >= off[1:0])
                && ({1'b0, 2'(k)} <= {1'b0, off[1:0]} + {1'b0, REQ_SIZE});
        end
        if (rel[32] || rel >= `QUMD_WIN_BYTES) begin
            tgt = TGT_NONE;
        end else if (off <= `QUMD_CHREG_LAST) begin
            tgt = TGT_CHREG;
        end else if (off >= `QUMD_SH_FIRST && off <= `QUMD_SH_LAST) begin
            tgt = TGT_SHARED;
        end else if (off >= `QUMD_FIFO_FIRST && off <= `QUMD_FIFO_LAST) begin
            tgt = TGT_FIFO;
        end else if (off >= `QUMD_RXST_FIRST) begin
            tgt = REQ_WRITE ? TGT_NONE : TGT_RXST;
        end else begin
            tgt = TGT_NONE;
        end
        txw = REQ_WRITE && tgt == TGT_FIFO;
    end

    ////////////////////////////////////////////////////////////////////
    // tx writes go straight into the fifo; a full fifo stalls the host
    qumd_fifo #(
        .W(`QUMD_TXW_W),
        .D(`QUMD_FIFO_D)
    ) u_txq (
        .clk(CLOCK),
        .rst_n(RST_N),
        .in_valid(REQ_VALID && txw),
        .in_ready(fifo_in_ready),
        .in_data({rel[11:10], be, REQ_WDATA}),
        .out_valid(TX_VALID),
        .out_ready(TX_READY),
        .out_data({TX_CHANNEL, TX_BE, TX_DATA})
    );
    assign REQ_READY = !txw || fifo_in_ready;
    assign take = REQ_VALID && REQ_READY;

    ////////////////////////////////////////////////////////////////////
    // one stage of request, so every strobe comes from a flop
    always_comb begin
        st_v_d = take && !txw;
        st_wr_d = REQ_WRITE;
        st_ch_d = rel[11:10];
        st_off_d = off;
        st_be_d = be;
        st_wd_d = REQ_WDATA;
        st_tgt_d = tgt;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_v_q <= 1'b0;
            st_wr_q <= 1'b0;
            st_ch_q <= 2'h0;
            st_off_q <= 10'h000;
            st_be_q <= 4'h0;
            st_wd_q <= 32'h0000_0000;
            st_tgt_q <= TGT_NONE;
        end else begin
            st_v_q <= st_v_d;
            st_wr_q <= st_wr_d;
            st_ch_q <= st_ch_d;
            st_off_q <= st_off_d;
            st_be_q <= st_be_d;
            st_wd_q <= st_wd_d;
            st_tgt_q <= st_tgt_d;
        end
    end

    // strobes toward the channel cores
    always_comb begin
        CHREG_RD = st_v_q && !st_wr_q && st_tgt_q == TGT_CHREG;
        CHREG_WR = st_v_q && st_wr_q && st_tgt_q == TGT_CHREG;
        CHREG_CHANNEL = st_ch_q;
        CHREG_INDEX = st_off_q[3:0];
        CHREG_BE = st_be_q;
        CHREG_WDATA = st_wd_q;
        RX_POP = st_v_q && !st_wr_q
            && (st_tgt_q == TGT_FIFO || st_tgt_q == TGT_RXST);
        RX_POP_STATUS = st_tgt_q == TGT_RXST;
        RX_POP_CHANNEL = st_ch_q;
        RX_POP_BYTES = 3'($countones(st_be_q));
    end

    ////////////////////////////////////////////////////////////////////
    // shared bytes; index is offset minus 0x80, same for all slices
    function automatic logic [7:0] sh_byte(input logic [9:0] o);
        logic [9:0] i;
        i = o - `QUMD_SH_FIRST;
        sh_byte = 8'h00;
        if (o >= `QUMD_SH_FIRST && i < 10'(`QUMD_SH_N)) begin
            if (i < 10'h004) begin
                sh_byte = INT_STATUS[8*i[1:0] +: 8];
            end else if (i[4:0] == `QUMD_SH_REV) begin
                sh_byte = REV_VALUE;
            end else if (i[4:0] == `QUMD_SH_ID) begin
                sh_byte = ID_VALUE;
            end else if (i[4:0] != `QUMD_SH_RST) begin
                sh_byte = sh_q[i[4:0]]; // reset byte reads zero
            end
        end
    endfunction : sh_byte

    // next value of each shared byte
    always_comb begin
        logic hit;
        logic [9:0] bo;
        hit = 1'b0;
        bo = 10'h000;
        rst_set = 4'h0;
        for (int i = 0; i < `QUMD_SH_N; i++) begin
            bo = `QUMD_SH_FIRST + 10'(i);
            hit = st_v_q && st_wr_q && st_tgt_q == TGT_SHARED
                && st_off_q[9:2] == bo[9:2] && st_be_q[bo[1:0]];
            sh_d[i] = sh_q[i];
            if (hit) begin
                case (5'(i))
                    `QUMD_SH_8X, `QUMD_SH_4X, `QUMD_SH_SLP: begin
                        sh_d[i][st_ch_q] = st_wd_q[8*bo[1:0] + st_ch_q];
                    end
                    `QUMD_SH_RST: begin
                        rst_set[st_ch_q] = st_wd_q[8*bo[1:0] + st_ch_q];
                    end
                    5'h00, 5'h01, 5'h02, 5'h03, `QUMD_SH_REV, `QUMD_SH_ID,
                    5'h1b: begin
                        sh_d[i] = sh_q[i]; // read-only or reserved
                    end
                    default: begin
                        sh_d[i] = st_wd_q[8*bo[1:0] +: 8];
                    end
                endcase
            end
        end
        // the set wins over a done in the same cycle
        rst_d = (rst_q & ~SOFT_RESET_DONE) | rst_set;
    end

    always_ff @(posedge CLOCK) begin
        for (int i = 0; i < `QUMD_SH_N; i++) begin
            if (!RST_N) begin
                sh_q[i] <= (5'(i) == `QUMD_SH_MPSEL_LO
                    || 5'(i) == `QUMD_SH_MPSEL_HI) ? `QUMD_MPSEL_RST : 8'h00;
            end else begin
                sh_q[i] <= sh_d[i];
            end
        end
        rst_q <= RST_N ? rst_d : 4'h0;
    end

    // per channel controls out
    always_comb begin
        EIGHT_TIMES_SAMPLING_SELECT = sh_q[`QUMD_SH_8X][3:0];
        FOUR_TIMES_SAMPLING_SELECT = sh_q[`QUMD_SH_4X][3:0];
        SLEEP_SELECT = sh_q[`QUMD_SH_SLP][3:0];
        SOFT_RESET = rst_q;
        for (int i = 0; i < `QUMD_SH_N; i++) begin
            CFG_BYTES[8*i +: 8] = sh_q[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read answer, registered one cycle after the strobe
    always_comb begin
        rsp_v_d = st_v_q && !st_wr_q;
        rsp_d = 32'h0000_0000; // reserved reads zero
        case (st_tgt_q)
            TGT_CHREG: rsp_d = CHREG_RDATA;
            TGT_FIFO, TGT_RXST: rsp_d = RX_RDATA;
            TGT_SHARED: begin
                for (int k = 0; k < 4; k++) begin
                    rsp_d[8*k +: 8] = sh_byte({st_off_q[9:2], 2'(k)});
                end
            end
            default: rsp_d = 32'h0000_0000;
        endcase
        for (int k = 0; k < 4; k++) begin
            if (!st_be_q[k]) begin
                rsp_d[8*k +: 8] = 8'h00;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            rsp_v_q <= 1'b0;
            rsp_q <= 32'h0000_0000;
        end else begin
            rsp_v_q <= rsp_v_d;
            rsp_q <= rsp_d;
        end
    end
    assign RSP_VALID = rsp_v_q;
    assign RSP_RDATA = rsp_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    rsp_timing_a: assert property (
        take && !REQ_WRITE |-> ##2 RSP_VALID)
        else $error("read answer not two cycles after take");
    outside_win_a: assert property (
        take && tgt == TGT_NONE && REQ_WRITE
        |=> !CHREG_WR && !CHREG_RD && !RX_POP && !TX_VALID)
        else $error("write outside window had effect");
    chreg_slice_a: assert property (
        take && tgt == TGT_CHREG |=> (CHREG_RD || CHREG_WR)
        && CHREG_CHANNEL == $past(rel[11:10]))
        else $error("channel register strobe wrong");
    pop_bytes_a: assert property (
        take && !REQ_WRITE && tgt == TGT_FIFO && REQ_SIZE == 2'h3
        && off[1:0] == 2'h0 |=> RX_POP && RX_POP_BYTES == 3'h4)
        else $error("rx pop byte count wrong");
    tx_push_a: assert property (
        take && txw |=> TX_VALID)
        else $error("tx write not queued");
    mode_own_a: assert property (
        st_v_q |=> ((EIGHT_TIMES_SAMPLING_SELECT
        ^ $past(EIGHT_TIMES_SAMPLING_SELECT))
        & ~(4'h1 << $past(st_ch_q))) == 4'h0)
        else $error("foreign channel bit changed");
    reset_clear_a: assert property (
        SOFT_RESET[0] && SOFT_RESET_DONE[0] && !rst_set[0]
        |=> !SOFT_RESET[0])
        else $error("soft reset bit did not clear");
    resv_zero_a: assert property (
        take && !REQ_WRITE && tgt == TGT_NONE |-> ##2 RSP_RDATA == 32'h0)
        else $error("reserved read not zero");
endmodule : qumd_decoder
`default_nettype wire

/* File: verification/qumd_uart_model.sv */
/* uart side model: register and rx answers, tx sink, soft reset done.
   assumes the decoder strobes are registered one-cycle pulses */
`timescale 1ns/100ps
`default_nettype none
module qumd_uart_model (
    // clock and tx stall control
    input wire logic clk,
    input wire logic hold,
    // register and rx reads
    input wire logic chreg_rd,
    input wire logic [1:0] chreg_ch,
    input wire logic [3:0] chreg_idx,
    output logic [31:0] chreg_rdata,
    input wire logic rx_pop,
    input wire logic rx_st,
    input wire logic [1:0] rx_ch,
    output logic [31:0] rx_rdata,
    // tx sink and soft reset
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [37:0] tx_word,
    input wire logic [3:0] srst,
    output logic [3:0] srst_done
);
    logic [31:0] junk_q = 32'h0;
    logic rdy_q = 1'b0;
    logic [3:0] done_q = 4'h0;
    logic [37:0] got[$];
    // outside the strobe cycle the data lines show noise, never old data
    assign chreg_rdata = chreg_rd ? {4{2'h0, chreg_ch, chreg_idx}} ^
        32'hc3a5_5a3c : junk_q;
    assign rx_rdata = rx_pop ? {4{1'b0, rx_st, 4'h9, rx_ch}} ^
        32'h6b1d_e247 : ~junk_q;
    assign tx_ready = rdy_q;
    assign srst_done = done_q;
    // random stalls; reset of a channel completes one cycle after request
    always @(posedge clk) begin
        junk_q <= junk_q + 32'h9e37_79b9;
        rdy_q <= !hold && ($urandom % 3 != 0);
        done_q <= srst;
        if (tx_valid && tx_ready) got.push_back(tx_word);
    end
endmodule : qumd_uart_model
`default_nettype wire

/* File: verification/test_qumd_decoder.sv */
/* self-checking bench of the memory window decoder.
   assumes qumd_uart_model answers the uart side */
`timescale 1ns/100ps
`default_nettype none
`include "qumd_consts.svh"
module test_qumd_decoder;
    import qumd_pkg::*;
    logic CLOCK = 1'b0, RST_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0;
    logic [31:0] BASE_ADDR = 32'h0, REQ_ADDR = 32'h0, REQ_WDATA = 32'h0;
    logic [31:0] INT_STATUS = 32'h0, CHREG_RDATA, RX_RDATA, RSP_RDATA;
    logic [31:0] TX_DATA, d, m;
    logic [1:0] REQ_SIZE = 2'h0, CHREG_CHANNEL, RX_POP_CHANNEL, TX_CHANNEL;
    logic [1:0] c, s;
    logic [3:0] CHREG_INDEX, TX_BE, m8, m4, msl, mrst, done, e8, e4, esl;
    logic [7:0] o;
    logic [2:0] RX_POP_BYTES, seen_bytes = 3'h0, cnt;
    logic REQ_READY, RSP_VALID, CHREG_RD, RX_POP, RX_POP_STATUS, TX_VALID;
    logic TX_READY, seen_st = 1'b0, hold = 1'b1;
    logic CHREG_WR;
    logic [3:0] CHREG_BE, seen_be = 4'h0;
    logic [31:0] CHREG_WDATA, seen_wd = 32'h0;
    logic [8*`QUMD_SH_N-1:0] CFG_BYTES;
    logic [7:0] v;
    int wr_count = 0;
    logic [37:0] ex[9], tw;
    logic [31:0] em[9];
    logic [12:0] rsv[5] = '{13'h010, 13'h47f, 13'h89b, 13'hcff, 13'h1004};
    int fail_count = 0, num_checks = 0;
    always #2 CLOCK = ~CLOCK;

    qumd_decoder i_qumd_decoder (.CLOCK(CLOCK), .RST_N(RST_N),
        .BASE_ADDR(BASE_ADDR), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_SIZE(REQ_SIZE),
        .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
        .CHREG_RD(CHREG_RD), .CHREG_WR(CHREG_WR),
        .CHREG_CHANNEL(CHREG_CHANNEL), .CHREG_INDEX(CHREG_INDEX),
        .CHREG_BE(CHREG_BE), .CHREG_WDATA(CHREG_WDATA),
        .CHREG_RDATA(CHREG_RDATA), .RX_POP(RX_POP),
        .RX_POP_STATUS(RX_POP_STATUS), .RX_POP_CHANNEL(RX_POP_CHANNEL),
        .RX_POP_BYTES(RX_POP_BYTES), .RX_RDATA(RX_RDATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_CHANNEL(TX_CHANNEL),
        .TX_BE(TX_BE), .TX_DATA(TX_DATA), .INT_STATUS(INT_STATUS),
        .EIGHT_TIMES_SAMPLING_SELECT(m8), .FOUR_TIMES_SAMPLING_SELECT(m4),
        .SLEEP_SELECT(msl), .SOFT_RESET(mrst), .SOFT_RESET_DONE(done),
        .CFG_BYTES(CFG_BYTES));
    qumd_uart_model i_qumd_uart_model (.clk(CLOCK), .hold(hold),
        .chreg_rd(CHREG_RD), .chreg_ch(CHREG_CHANNEL),
        .chreg_idx(CHREG_INDEX), .chreg_rdata(CHREG_RDATA), .rx_pop(RX_POP),
        .rx_st(RX_POP_STATUS), .rx_ch(RX_POP_CHANNEL), .rx_rdata(RX_RDATA),
        .tx_valid(TX_VALID), .tx_ready(TX_READY),
        .tx_word({TX_CHANNEL, TX_BE, TX_DATA}), .srst(mrst),
        .srst_done(done));

    ////////////////////////////////////////////////////////////////////
    // remember what the last rx unload and channel register write looked like
    always @(posedge CLOCK) begin
        if (RX_POP) begin
            seen_bytes <= RX_POP_BYTES;
            seen_st <= RX_POP_STATUS;
        end
        if (CHREG_WR) begin
            seen_be <= CHREG_BE;
            seen_wd <= CHREG_WDATA;
            wr_count <= wr_count + 1;
        end
    end

    task automatic check(input string what, input logic [37:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // byte lanes of an access; lanes past 3 are dropped
    function automatic logic [31:0] lanes(input logic [1:0] a, sz);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 4; i++) begin
            if (i >= a && i <= a + sz) r[8*i +: 8] = 8'hff;
        end
        return r;
    endfunction : lanes

    // one host access, held until taken; the bound stops a hang
    task automatic req(input logic w, input logic [12:0] off,
            input logic [1:0] sz, input logic [31:0] wd);
        logic ok;
        ok = 1'b0;
        REQ_VALID <= 1'b1;
        REQ_WRITE <= w;
        REQ_ADDR <= BASE_ADDR + {19'h0, off};
        REQ_SIZE <= sz;
        REQ_WDATA <= wd;
        for (int n = 0; n < 60 && ok !== 1'b1; n++) begin
            @(negedge CLOCK) ok = REQ_READY;
            @(posedge CLOCK);
        end
        if (ok !== 1'b1) begin
            check("req_ready", 38'h0, 38'h1);
            end_of_test;
        end
        REQ_VALID <= 1'b0;
        @(posedge CLOCK);
    endtask : req

    task automatic rd(input logic [12:0] off, input logic [1:0] sz,
            input logic [31:0] exp, input string what);
        req(1'b0, off, sz, 32'h0);
        #1;
        for (int n = 0; n < 4 && RSP_VALID !== 1'b1; n++) begin
            @(posedge CLOCK);
            #1;
        end
        check("rsp_valid", RSP_VALID, 1'b1);
        check(what, RSP_RDATA, exp & lanes(off[1:0], sz));
    endtask : rd

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf2eb7b1b));
        BASE_ADDR <= $urandom & 32'hffff_f000;
        INT_STATUS <= $urandom;
        {e8, e4, esl} = 12'h0;
        repeat (4) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        check("reset", {m8, m4, msl, mrst}, 16'h0);
        check("cfg_reset", {CFG_BYTES[8*19 +: 8], CFG_BYTES[8*25 +: 8]},
            16'hffff);
        // per-channel bits: set then clear, other bits random
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 16; k++) begin
                c = k[3:2];
                if (k[1:0] == 2'h2) continue;
                d = $urandom;
                d[c] = (r == 0);
                req(1'b1, {1'b0, c, 10'h088} + k[1:0], 2'h0, {4{d[7:0]}});
                if (k[1:0] == 2'h0) e8[c] = d[c];
                if (k[1:0] == 2'h1) e4[c] = d[c];
                if (k[1:0] == 2'h3) esl[c] = d[c];
                repeat (2) @(posedge CLOCK);
                check("modes", {m8, m4, msl}, {e8, e4, esl});
            end
            c = $urandom;
            rd({1'b0, c, 10'h088}, 2'h3, {4'h0, esl, 12'h0, e4, 4'h0, e8},
                "shared");
        end
        for (int k = 0; k < 4; k++) begin
            req(1'b1, {1'b0, k[1:0], 10'h08a}, 2'h0, 32'h00ff_0000);
            for (int n = 0; n < 4 && mrst === 4'h0; n++) @(posedge CLOCK);
            check("soft_reset", mrst, 4'h1 << k);
            for (int n = 0; n < 8 && mrst !== 4'h0; n++) @(posedge CLOCK);
            check("self_clear", mrst, 4'h0);
        end
        foreach (rsv[i]) rd(rsv[i], 2'h3, 32'h0, "reserved");
        for (int n = 0; n < 24; n++) begin
            c = $urandom;
            o = $urandom;
            s = $urandom;
            rd({1'b0, c, 6'h0, o[3:0]}, s, {4{2'h0, c, o[3:0]}} ^
                32'hc3a5_5a3c, "chreg");
            rd({1'b0, c, 10'h080}, 2'h3, INT_STATUS, "int");
            d = $urandom;
            m = lanes(o[1:0], s);
            req(1'b1, {1'b0, c, 6'h0, o[3:0]}, s, d);
            #1;
            check("chreg_wr", {seen_be, seen_wd & m},
                {m[24], m[16], m[8], m[0], d & m});
            check("chreg_wr_count", wr_count, n + 1);
            v = $urandom;
            req(1'b1, {1'b0, c, 10'h084}, 2'h0, {4{v}});
            rd({1'b0, ~c, 10'h084}, 2'h0, {4{v}}, "shared_rw");
            check("cfg_byte", CFG_BYTES[8*4 +: 8], v);
            rd({1'b0, c, 2'h1, o}, s, {4{6'h09, c}} ^ 32'h6b1d_e247,
                "rx");
            cnt = (o[1:0] + s > 3) ? 3'h4 - o[1:0] : s + 3'h1;
            check("pop_bytes", {seen_st, seen_bytes}, {1'b0, cnt});
            s = o[7] ? 2'h1 : 2'h3;
            o = o & (o[7] ? 8'hfe : 8'hfc);
            rd({1'b0, c, 1'b1, o[7], o}, s, {4{6'h19, c}} ^ 32'h6b1d_e247,
                "rx_status");
            check("status_pop", seen_st, 1'b1);
        end
        // fill the tx fifo with the sink stalled, then one more is refused
        for (int n = 0; n < 9; n++) begin
            c = $urandom;
            o = $urandom;
            s = $urandom;
            d = $urandom;
            m = lanes(o[1:0], s);
            em[n] = m;
            ex[n] = {c, m[24], m[16], m[8], m[0], d & m};
            if (n < 8) req(1'b1, {1'b0, c, 2'h1, o}, s, d);
            else begin
                fork
                    req(1'b1, {1'b0, c, 2'h1, o}, s, d);
                join_none
                @(negedge CLOCK);
                check("full", REQ_READY, 1'b0);
                @(posedge CLOCK);
                hold <= 1'b0;
                wait fork;
            end
        end
        for (int n = 0; n < 200 && i_qumd_uart_model.got.size() < 9; n++)
            @(posedge CLOCK);
        check("tx_count", i_qumd_uart_model.got.size(), 9);
        for (int n = 0; n < 9 && n < i_qumd_uart_model.got.size(); n++) begin
            tw = i_qumd_uart_model.got[n];
            check("tx_word", {tw[37:32], tw[31:0] & em[n]}, ex[n]);
        end
        req(1'b1, 13'h0200, 2'h3, 32'h1);
        repeat (3) @(posedge CLOCK);
        check("tx_empty", TX_VALID, 1'b0);
        end_of_test;
    end
endmodule : test_qumd_decoder
`default_nettype wire
